//--- pkg/hcd_dec_if.sv
/*
 * Carrier between the sampling stage and the commutation table.
 * Assumes the code and direction are held stable by registers upstream.
 */
`timescale 1ns/1ps
`default_nettype none

interface hcd_dec_if;
    import hcd_pkg::*;

    hcd_code_t code;
    logic      dir;
    hcd_sw_t   hs;
    hcd_sw_t   ls;
    logic      pulse;

    modport dec (input code, input dir, output hs, output ls, output pulse);
    modport ctl (output code, output dir, input hs, input ls, input pulse);
endinterface

`default_nettype wire

//--- pkg/hcd_pkg.sv
/*
 * Shared constants for the Hall commutation decoder: phase bit positions,
 * switch masks, Hall codes, input width and reset values.
 * Assumes every design file imports the whole package.
 */
`default_nettype none

package hcd_pkg;

    // phase positions inside a code or switch vector, U is the msb
    localparam int HCD_PH_U = 2;
    localparam int HCD_PH_V = 1;
    localparam int HCD_PH_W = 0;

    localparam int HCD_CODE_W = 3;
    localparam int HCD_HALL_W = 8;
    localparam int HCD_LATENCY = 2;

    typedef logic [HCD_CODE_W-1:0] hcd_code_t;
    typedef logic [HCD_CODE_W-1:0] hcd_sw_t;

    // switch masks: all off, then one-hot with one bit per phase
    localparam hcd_sw_t HCD_SW_OFF = 3'h0;
    localparam hcd_sw_t HCD_SW_U   = 3'h4;
    localparam hcd_sw_t HCD_SW_V   = 3'h2;
    localparam hcd_sw_t HCD_SW_W   = 3'h1;

    // Hall codes written as UVW
    localparam hcd_code_t HCD_CODE_000 = 3'h0;
    localparam hcd_code_t HCD_CODE_001 = 3'h1;
    localparam hcd_code_t HCD_CODE_010 = 3'h2;
    localparam hcd_code_t HCD_CODE_011 = 3'h3;
    localparam hcd_code_t HCD_CODE_100 = 3'h4;
    localparam hcd_code_t HCD_CODE_101 = 3'h5;
    localparam hcd_code_t HCD_CODE_110 = 3'h6;
    localparam hcd_code_t HCD_CODE_111 = 3'h7;

    // reset values
    localparam hcd_code_t HCD_CODE_RST  = 3'h0;
    localparam logic      HCD_DIR_RST   = 1'b0;
    localparam logic      HCD_PULSE_RST = 1'b0;

    // true when no more than one bit of a switch vector is set
    function automatic logic hcd_at_most_one(input hcd_sw_t x);
        return (x & (x - 3'h1)) == 3'h0;
    endfunction

endpackage

`default_nettype wire

//--- rtl/hall_commutation_decoder.sv
/*
 * Top of the Hall commutation decoder: compares each differential Hall
 * pair, samples code and direction, decodes and registers the six switch
 * commands and the rotation pulse.
 * Assumes Hall words and direction are synchronous to clock_in, and that
 * gate drivers downstream add their own dead time.
 */
// Notes on behaviour
// - a Hall phase reads high only when its positive input exceeds the negative one
// - each phase has its own pair; analog element or digital Hall IC both work
// - forward: 101 UhVl, 100 UhWl, 110 VhWl, 010 VhUl, 011 WhUl, 001 WhVl
// - reverse: 101 VhUl, 100 WhUl, 110 WhVl, 010 UhVl, 011 UhWl, 001 VhWl
// - pulse high forward on 100/010/001, reverse on 101/110/011, else low
`timescale 1ns/1ps
`default_nettype none

module hall_commutation_decoder
    import hcd_pkg::*;
#(
    parameter int HALL_W = HCD_HALL_W
) (
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic [HALL_W-1:0] hall_u_pos_in,
    input  wire logic [HALL_W-1:0] hall_u_neg_in,
    input  wire logic [HALL_W-1:0] hall_v_pos_in,
    input  wire logic [HALL_W-1:0] hall_v_neg_in,
    input  wire logic [HALL_W-1:0] hall_w_pos_in,
    input  wire logic [HALL_W-1:0] hall_w_neg_in,
    input  wire logic              direction_select_in,
    output logic [2:0]             high_side_out,
    output logic [2:0]             low_side_out,
    output logic                   rotation_pulse_out
);

    // strict compare: equal inputs read low, so a floating or shorted pair stays low
    function automatic logic hcd_above(input logic [HALL_W-1:0] p, input logic [HALL_W-1:0] n);
        return p > n;
    endfunction

    hcd_code_t raw_code;
    hcd_code_t code_r;
    logic      dir_r;
    logic      cmd_safe;
    hcd_sw_t   hs_nxt;
    hcd_sw_t   ls_nxt;
    logic      pulse_nxt;
    hcd_sw_t   hs_r;
    hcd_sw_t   ls_r;
    logic      pulse_r;

    hcd_dec_if dec_if ();

    // one comparator per phase, a digital Hall IC simply drives full scale against a mid level
    assign raw_code[HCD_PH_U] = hcd_above(hall_u_pos_in, hall_u_neg_in);
    assign raw_code[HCD_PH_V] = hcd_above(hall_v_pos_in, hall_v_neg_in);
    assign raw_code[HCD_PH_W] = hcd_above(hall_w_pos_in, hall_w_neg_in);

    // sample stage: code and direction change together so the table never sees a mix
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            code_r <= HCD_CODE_RST;
            dir_r  <= HCD_DIR_RST;
        end else if (ce_in) begin
            code_r <= raw_code;
            dir_r  <= direction_select_in;
        end
    end

    assign dec_if.code = code_r;
    assign dec_if.dir  = dir_r;

    hcd_decode u_decode (
        .dec_if (dec_if.dec)
    );

    // last-line interlock: any command that could short a leg is dropped to all off
    assign cmd_safe  = ((dec_if.hs & dec_if.ls) == HCD_SW_OFF) &&
                       hcd_at_most_one(dec_if.hs) && hcd_at_most_one(dec_if.ls);
    assign hs_nxt    = cmd_safe ? dec_if.hs : HCD_SW_OFF;
    assign ls_nxt    = cmd_safe ? dec_if.ls : HCD_SW_OFF;
    assign pulse_nxt = dec_if.pulse;

    // output stage: registered so gate drivers never see decode glitches
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hs_r    <= HCD_SW_OFF;
            ls_r    <= HCD_SW_OFF;
            pulse_r <= HCD_PULSE_RST;
        end else if (ce_in) begin
            hs_r    <= hs_nxt;
            ls_r    <= ls_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign high_side_out      = hs_r;
    assign low_side_out       = ls_r;
    assign rotation_pulse_out = pulse_r;

    // checks below watch the two-stage path from pins to outputs
    // sampled reset in the sequence and phase-level triggers skips the release edge, where the flops still load reset values

    // forward, code 101, then one more enabled edge
    sequence s_fwd_101;
        rst_n_in && ce_in && direction_select_in && (raw_code == HCD_CODE_101) ##1 ce_in;
    endsequence

    // forward, code 010
    sequence s_fwd_010;
        rst_n_in && ce_in && direction_select_in && (raw_code == HCD_CODE_010) ##1 ce_in;
    endsequence

    // reverse, code 100
    sequence s_rev_100;
        rst_n_in && ce_in && !direction_select_in && (raw_code == HCD_CODE_100) ##1 ce_in;
    endsequence

    // reverse, code 011
    sequence s_rev_011;
        rst_n_in && ce_in && !direction_select_in && (raw_code == HCD_CODE_011) ##1 ce_in;
    endsequence

    // either invalid code, any direction
    sequence s_invalid;
        rst_n_in && ce_in && ((raw_code == HCD_CODE_000) || (raw_code == HCD_CODE_111)) ##1 ce_in;
    endsequence

    // forward, code 110
    sequence s_fwd_110;
        rst_n_in && ce_in && direction_select_in && (raw_code == HCD_CODE_110) ##1 ce_in;
    endsequence

    // forward, code 001
    sequence s_fwd_001;
        rst_n_in && ce_in && direction_select_in && (raw_code == HCD_CODE_001) ##1 ce_in;
    endsequence

    // reverse, code 101
    sequence s_rev_101;
        rst_n_in && ce_in && !direction_select_in && (raw_code == HCD_CODE_101) ##1 ce_in;
    endsequence

    // reverse, code 010
    sequence s_rev_010;
        rst_n_in && ce_in && !direction_select_in && (raw_code == HCD_CODE_010) ##1 ce_in;
    endsequence

    // reverse, code 001
    sequence s_rev_001;
        rst_n_in && ce_in && !direction_select_in && (raw_code == HCD_CODE_001) ##1 ce_in;
    endsequence

    a_sense_polarity: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        rst_n_in && ce_in |=> (code_r[HCD_PH_U] == ($past(hall_u_pos_in) > $past(hall_u_neg_in))))
        else $error("u phase level does not follow pos above neg");

    a_phase_pairs: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        rst_n_in && ce_in |=> (code_r[HCD_PH_V] == ($past(hall_v_pos_in) > $past(hall_v_neg_in))) &&
                              (code_r[HCD_PH_W] == ($past(hall_w_pos_in) > $past(hall_w_neg_in))))
        else $error("v or w phase level does not follow its own pair");

    a_forward_101: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_fwd_101 |=> (high_side_out == HCD_SW_U) && (low_side_out == HCD_SW_V) && !rotation_pulse_out)
        else $error("forward 101 did not give u high v low");

    a_forward_010: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_fwd_010 |=> (high_side_out == HCD_SW_V) && (low_side_out == HCD_SW_U) && rotation_pulse_out)
        else $error("forward 010 did not give v high u low");

    a_forward_110: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_fwd_110 |=> (high_side_out == HCD_SW_V) && (low_side_out == HCD_SW_W) && !rotation_pulse_out)
        else $error("forward 110 did not give v high w low");

    a_forward_001: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_fwd_001 |=> (high_side_out == HCD_SW_W) && (low_side_out == HCD_SW_V) && rotation_pulse_out)
        else $error("forward 001 did not give w high v low");

    a_reverse_100: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_rev_100 |=> (high_side_out == HCD_SW_W) && (low_side_out == HCD_SW_U) && !rotation_pulse_out)
        else $error("reverse 100 did not give w high u low");

    a_reverse_101: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_rev_101 |=> (high_side_out == HCD_SW_V) && (low_side_out == HCD_SW_U) && rotation_pulse_out)
        else $error("reverse 101 did not give v high u low");

    a_reverse_010: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_rev_010 |=> (high_side_out == HCD_SW_U) && (low_side_out == HCD_SW_V) && !rotation_pulse_out)
        else $error("reverse 010 did not give u high v low");

    a_reverse_001: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_rev_001 |=> (high_side_out == HCD_SW_V) && (low_side_out == HCD_SW_W) && !rotation_pulse_out)
        else $error("reverse 001 did not give v high w low");

    a_invalid_off: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_invalid |=> (high_side_out == HCD_SW_OFF) && (low_side_out == HCD_SW_OFF) && !rotation_pulse_out)
        else $error("invalid hall code left a switch or pulse on");

    a_pulse_reverse: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_rev_011 |=> rotation_pulse_out && (high_side_out == HCD_SW_U) && (low_side_out == HCD_SW_W))
        else $error("reverse 011 did not raise the pulse");

    a_pulse_follows: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        $rose(rotation_pulse_out) |-> $past(dir_r) ? hcd_at_most_one($past(code_r))
                                                   : !hcd_at_most_one($past(code_r)))
        else $error("pulse rose on a code of the wrong kind for the direction");

    a_no_shoot: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        ((high_side_out & low_side_out) == HCD_SW_OFF) &&
        hcd_at_most_one(high_side_out) && hcd_at_most_one(low_side_out))
        else $error("conflicting switch commands on the outputs");

    a_frozen_hold: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        !ce_in |=> $stable(high_side_out) && $stable(low_side_out) && $stable(rotation_pulse_out))
        else $error("outputs moved while clock enable was low");

endmodule // hall_commutation_decoder

`default_nettype wire

//--- rtl/hcd_decode.sv
/*
 * Combinational commutation table: Hall code and direction to switch
 * commands and rotation pulse level.
 * Assumes the code arrives from a register; outputs are registered later.
 */
`timescale 1ns/1ps
`default_nettype none

module hcd_decode
    import hcd_pkg::*;
(
    hcd_dec_if.dec dec_if
);

    logic    u;
    logic    v;
    logic    w;
    logic    code_valid;
    logic    one_high;
    logic    two_high;
    hcd_sw_t lead_sw;
    hcd_sw_t lag_sw;

    assign u = dec_if.code[HCD_PH_U];
    assign v = dec_if.code[HCD_PH_V];
    assign w = dec_if.code[HCD_PH_W];

    // 000 and 111 are not a rotor position, the closed forms below give zero there
    assign code_valid = (dec_if.code != HCD_CODE_000) && (dec_if.code != HCD_CODE_111);

    // forward high side: 10x->U, x10->V, 0x1->W
    assign lead_sw[HCD_PH_U] = u & ~v;
    assign lead_sw[HCD_PH_V] = v & ~w;
    assign lead_sw[HCD_PH_W] = w & ~u;
    // forward low side: x01->V, 01x->U, 1x0->W
    assign lag_sw[HCD_PH_U] = v & ~u;
    assign lag_sw[HCD_PH_V] = w & ~v;
    assign lag_sw[HCD_PH_W] = u & ~w;

    // reverse is the forward table with high and low sides swapped
    assign dec_if.hs = dec_if.dir ? lead_sw : lag_sw;
    assign dec_if.ls = dec_if.dir ? lag_sw : lead_sw;

    // pulse: single-bit codes forward, two-bit codes reverse
    assign one_high = (dec_if.code == HCD_CODE_100) || (dec_if.code == HCD_CODE_010) ||
                      (dec_if.code == HCD_CODE_001);
    assign two_high = (dec_if.code == HCD_CODE_101) || (dec_if.code == HCD_CODE_110) ||
                      (dec_if.code == HCD_CODE_011);
    assign dec_if.pulse = code_valid & (dec_if.dir ? one_high : two_high);

endmodule // hcd_decode

`default_nettype wire

//--- tb/hall_commutation_decoder_test.sv
/*
 * Self-checking bench for the Hall commutation decoder.
 * Assumes the two-edge latency and clock-enable freeze of the design.
 */
`timescale 1ns/1ps
`default_nettype none

module hall_commutation_decoder_test;
    import hcd_pkg::*;

    logic              clock_in    = 1'b0;
    logic              rst_n_r     = 1'b0;
    logic              ce_r        = 1'b1;
    logic              dir_r       = 1'b1;
    logic              digital_r   = 1'b0;
    hcd_code_t         code_r      = HCD_CODE_000;
    int                error_cnt   = 0;
    int                checks_done = 0;
    int                cycle_cnt   = 0;
    wire logic [HCD_HALL_W-1:0] up_w, un_w, vp_w, vn_w, wp_w, wn_w;
    wire logic [2:0]   hs_w, ls_w;
    wire logic         pulse_w;
    wire logic [6:0]   outs_w = {hs_w, ls_w, pulse_w};

    // 10 MHz clock
    always #50 clock_in = ~clock_in;

    hcd_hall_model i_hall (.digital_in(digital_r), .code_in(code_r),
        .u_pos_out(up_w), .u_neg_out(un_w), .v_pos_out(vp_w),
        .v_neg_out(vn_w), .w_pos_out(wp_w), .w_neg_out(wn_w));

    hall_commutation_decoder i_dut (.clock_in(clock_in), .rst_n_in(rst_n_r),
        .ce_in(ce_r), .hall_u_pos_in(up_w), .hall_u_neg_in(un_w),
        .hall_v_pos_in(vp_w), .hall_v_neg_in(vn_w), .hall_w_pos_in(wp_w),
        .hall_w_neg_in(wn_w), .direction_select_in(dir_r),
        .high_side_out(hs_w), .low_side_out(ls_w), .rotation_pulse_out(pulse_w));

    // expected {high, low, pulse}; reverse on a valid code swaps the sides and inverts pulse
    function automatic logic [6:0] exp_f(input hcd_code_t c, input logic d);
        hcd_sw_t h;
        hcd_sw_t l;
        logic    p;
        case (c)
            HCD_CODE_101: begin h = HCD_SW_U; l = HCD_SW_V; p = 1'b0; end
            HCD_CODE_100: begin h = HCD_SW_U; l = HCD_SW_W; p = 1'b1; end
            HCD_CODE_110: begin h = HCD_SW_V; l = HCD_SW_W; p = 1'b0; end
            HCD_CODE_010: begin h = HCD_SW_V; l = HCD_SW_U; p = 1'b1; end
            HCD_CODE_011: begin h = HCD_SW_W; l = HCD_SW_U; p = 1'b0; end
            HCD_CODE_001: begin h = HCD_SW_W; l = HCD_SW_V; p = 1'b1; end
            default:      begin h = HCD_SW_OFF; l = HCD_SW_OFF; p = 1'b0; end
        endcase
        if (!d && h != HCD_SW_OFF) return {l, h, ~p};
        return {h, l, p};
    endfunction

    task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // every code, both directions, both source kinds, a new input each cycle
    task automatic sweep_test();
        int k;
        for (int m = 0; m < 32 + HCD_LATENCY; m++) begin
            @(posedge clock_in);
            if (m < 32) begin
                code_r    <= m[2:0];
                dir_r     <= m[3];
                digital_r <= m[4];
            end
            #1;
            k = m - HCD_LATENCY;
            if (m >= HCD_LATENCY) check("table", outs_w, exp_f(k[2:0], k[3]));
            check("interlock", {4'h0, |(hs_w & ls_w), $countones(hs_w) > 1, $countones(ls_w) > 1}, 7'h00);
        end
    endtask

    // low clock enable holds the last command while inputs move
    task automatic freeze_test();
        @(posedge clock_in);
        code_r <= HCD_CODE_100;
        dir_r  <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1 check("freeze_ref", outs_w, exp_f(HCD_CODE_100, 1'b1));
        @(posedge clock_in);
        ce_r   <= 1'b0;
        code_r <= HCD_CODE_011;
        dir_r  <= 1'b0;
        repeat (4) @(posedge clock_in);
        #1 check("freeze_hold", outs_w, exp_f(HCD_CODE_100, 1'b1));
        @(posedge clock_in);
        ce_r <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1 check("freeze_wake", outs_w, exp_f(HCD_CODE_011, 1'b0));
    endtask

    // reset in mid-run clears every command at once, then decoding resumes
    task automatic reset_test();
        @(posedge clock_in);
        rst_n_r <= 1'b0;
        #1 check("reset_off", outs_w, 7'h00);
        @(posedge clock_in);
        rst_n_r <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1 check("reset_resume", outs_w, exp_f(HCD_CODE_011, 1'b0));
    endtask

    // hang guard, well above the roughly 55 cycles the scenarios need
    always @(posedge clock_in) begin
        cycle_cnt++;
        if (cycle_cnt >= 2000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        repeat (6) @(posedge clock_in);
        rst_n_r <= 1'b1;
        sweep_test();
        freeze_test();
        reset_test();
        stop_test();
    end
endmodule // hall_commutation_decoder_test

`default_nettype wire

//--- tb/hcd_hall_model.sv
/*
 * Behavioural model of the three Hall sources feeding the decoder.
 * Assumes the bench sets the code and source kind just after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module hcd_hall_model
    import hcd_pkg::*;
#(
    parameter int HALL_W = HCD_HALL_W
) (
    input  wire logic              digital_in,
    input  wire hcd_code_t         code_in,
    output logic [HALL_W-1:0]      u_pos_out,
    output logic [HALL_W-1:0]      u_neg_out,
    output logic [HALL_W-1:0]      v_pos_out,
    output logic [HALL_W-1:0]      v_neg_out,
    output logic [HALL_W-1:0]      w_pos_out,
    output logic [HALL_W-1:0]      w_neg_out
);
    // analog element sits on the decision boundary: low is pos equal to neg, high is one step above
    // digital source swings rail to rail against a mid-level reference
    wire logic [HALL_W-1:0] mid_w = {1'b1, {(HALL_W-1){1'b0}}};
    wire logic [HALL_W-1:0] hi_w  = digital_in ? {HALL_W{1'b1}} : mid_w + 1'b1;
    wire logic [HALL_W-1:0] lo_w  = digital_in ? {HALL_W{1'b0}} : mid_w;

    // one pair per phase, same reference on every negative input
    assign u_pos_out = code_in[HCD_PH_U] ? hi_w : lo_w;
    assign v_pos_out = code_in[HCD_PH_V] ? hi_w : lo_w;
    assign w_pos_out = code_in[HCD_PH_W] ? hi_w : lo_w;
    assign u_neg_out = mid_w;
    assign v_neg_out = mid_w;
    assign w_neg_out = mid_w;
endmodule // hcd_hall_model

`default_nettype wire
